/* File: hw/oscd_pkg.sv */
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
package oscd_pkg;
	// Command opcodes
	localparam logic [7:0] OP_COL_WIN   = 8'h15;
	localparam logic [7:0] OP_ROW_WIN   = 8'h75;
	localparam logic [7:0] OP_CONTRAST  = 8'h81;
	localparam logic [7:0] OP_RANGE_Q   = 8'h84;
	localparam logic [7:0] OP_RANGE_F   = 8'h86;
	localparam logic [7:0] OP_REMAP     = 8'hA0;
	localparam logic [7:0] OP_START     = 8'hA1;
	localparam logic [7:0] OP_OFFSET    = 8'hA2;
	localparam logic [7:0] OP_MODE_NORM = 8'hA4;
	localparam logic [7:0] OP_MODE_INV  = 8'hA7;
	localparam logic [7:0] OP_MUX       = 8'hA8;
	localparam logic [7:0] OP_MASTER    = 8'hAD;
	localparam logic [7:0] OP_OFF       = 8'hAE;
	localparam logic [7:0] OP_ON        = 8'hAF;
	localparam logic [7:0] OP_PRECOMP   = 8'hB0;
	localparam logic [7:0] OP_PHASE     = 8'hB1;
	localparam logic [7:0] OP_NOP       = 8'hE3;
	// Reset values and limits
	localparam logic [5:0] COL_START_RST = 6'h00;
	localparam logic [5:0] COL_END_RST   = 6'h3F;
	localparam logic [6:0] ROW_START_RST = 7'h00;
	localparam logic [6:0] ROW_END_RST   = 7'h4F;
	localparam logic [6:0] LINE_MAX      = 7'h4F;
	localparam logic [6:0] CONTRAST_RST  = 7'h40;
	localparam logic [6:0] REMAP_RST     = 7'h00;
	localparam logic [6:0] REMAP_MASK    = 7'h57;
	localparam int         REMAP_VERT    = 2;
	localparam logic [6:0] LINE_RST      = 7'h00;
	localparam logic [6:0] MUX_MIN       = 7'h0F;
	localparam logic [6:0] MUX_LINES_RST = 7'h50;
	localparam logic       EXT_SUPPLY_RST = 1'b1;
	localparam int         MASTER_BIT    = 0;
	localparam logic [5:0] PRECOMP_RST   = 6'h08;
	localparam logic [3:0] PHASE1_RST    = 4'h3;
	localparam logic [3:0] PHASE2_RST    = 4'h5;
	localparam logic [3:0] PHASE_INVALID = 4'h0;
	localparam logic [1:0] RANGE_QUARTER = 2'h0;
	localparam logic [1:0] RANGE_FULL    = 2'h2;
	localparam logic [1:0] MODE_NORMAL   = 2'h0;
	localparam logic [2:0] LAST_BIT      = 3'h7;
	// Display-on delay before panel outputs switch on
	localparam int CLK_HZ       = 100000000;
	localparam int ON_DELAY_MS  = 100;
	localparam int ON_DELAY_CYC = CLK_HZ / 1000 * ON_DELAY_MS;
	// APB register map
	localparam logic [11:0] ADDR_STATUS = 12'h000;
	localparam logic [11:0] ADDR_WINDOW = 12'h004;
	localparam logic [11:0] ADDR_CONFIG = 12'h008;
	localparam logic [11:0] ADDR_LINES  = 12'h00C;
	localparam logic [11:0] ADDR_CTRL   = 12'h010;
	localparam int          CTRL_EN_BIT = 0;
	localparam logic [31:0] CTRL_RST    = 32'h0000_0001;
	// Command decoder states
	typedef enum logic [1:0] {
		DEC_OPCODE = 2'b00,
		DEC_PARAM1 = 2'b01,
		DEC_PARAM2 = 2'b10
	} oscd_dec_e;
endpackage : oscd_pkg
`default_nettype wire

/* File: hw/oscd_byte_if.sv */
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Received serial byte with its command/data flag
interface oscd_byte_if;
	logic       valid;
	logic [7:0] data;
	logic       dc;
	modport src (output valid, output data, output dc);
	modport dst (input valid, input data, input dc);
endinterface : oscd_byte_if
`default_nettype wire

/* File: hw/oscd_shift.sv */
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module oscd_shift
	import oscd_pkg::*;
(
	// System
	input  wire logic pclk,
	input  wire logic presetn,
	// Serial pins
	input  wire logic chip_select_n,
	input  wire logic serial_clock_in,
	input  wire logic serial_data_in,
	input  wire logic cmd_data_sel,
	input  wire logic bus_mode_select,
	// Byte out
	oscd_byte_if.src  bif
);
	logic [4:0] meta_reg;
	logic [4:0] sync_reg;
	logic       sclk_d_reg;
	logic [7:0] shift_reg;
	logic [2:0] cnt_reg;

	// Pin decode after synchronisers
	wire cs_active = ~sync_reg[4] & ~sync_reg[0];
	wire sclk_rise = sync_reg[3] & ~sclk_d_reg;
	wire bit_take  = cs_active & sclk_rise;
	wire byte_end  = bit_take & (cnt_reg == LAST_BIT);

	// Two-stage synchronisers: {cs_n, sclk, serial_data_in, dc, mode}
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta_reg <= 5'h1F;
			sync_reg <= 5'h1F;
		end
		else
		begin
			meta_reg <= {chip_select_n, serial_clock_in, serial_data_in,
				cmd_data_sel, bus_mode_select};
			sync_reg <= meta_reg;
		end
	end

	// Shift MSB first on sclk rise while selected
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sclk_d_reg <= 1'b1;
			shift_reg  <= 8'h00;
			cnt_reg    <= 3'h0;
		end
		else
		begin
			sclk_d_reg <= sync_reg[3];
			if (!cs_active)
				cnt_reg <= 3'h0;
			else if (bit_take)
			begin
				shift_reg <= {shift_reg[6:0], sync_reg[2]};
				cnt_reg   <= cnt_reg + 3'h1;
			end
		end
	end

	// Byte strobe, dc sampled with the eighth bit
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			bif.valid <= 1'b0;
			bif.data  <= 8'h00;
			bif.dc    <= 1'b0;
		end
		else
		begin
			bif.valid <= byte_end;
			if (byte_end)
			begin
				bif.data <= {shift_reg[6:0], sync_reg[2]};
				bif.dc   <= sync_reg[1];
			end
		end
	end

	a_cs_gate: assert property (@(posedge pclk) disable iff (!presetn)
		!cs_active |=> !bif.valid)
		else $error("byte produced while deselected");
endmodule : oscd_shift
`default_nettype wire

/* File: hw/oscd_top.sv */
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// What this block does
// - Command bytes arrive with dc low
// - Serial bytes accepted only while selected
// - D0 is serial clock, D1 data
// - 15h sets column window, reset 0..3Fh
// - 75h sets row window, reset 0..4Fh
// - 81h sets contrast, reset 40h
// - 84h-86h select current range, quarter reset
// - A0h bits 0-2 column, nibble, vertical
// - A0h bit4 common remap, bit6 split
// - A1h loads display start line
// - A2h sets vertical display offset
// - A4h-A7h select display mode
// - A8h sets multiplex ratio value plus one
// - ADh bit0 low selects external supply
// - Master config applies at display-on
// - AEh display off, AFh display on
// - B0h sets precharge compensation, reset 08h
// - B1h low nibble phase one length
// - Outputs enable 100ms after display-on
// - B1h high nibble phase two, zero invalid
// - Serial link is write-only
// - E3h changes nothing
module oscd_top
	import oscd_pkg::*;
#(
	parameter int ON_DELAY = ON_DELAY_CYC
)(
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Serial pins
	input  wire logic        chip_select_n,
	input  wire logic        reset_low_pin_n,
	input  wire logic        bus_mode_select,
	input  wire logic        cmd_data_sel,
	input  wire logic        serial_clock_in,
	input  wire logic        serial_data_in,
	// Panel settings
	output logic      [5:0]  col_start,
	output logic      [5:0]  col_end,
	output logic      [6:0]  row_start,
	output logic      [6:0]  row_end,
	output logic      [6:0]  contrast,
	output logic      [1:0]  current_range,
	output logic      [6:0]  remap,
	output logic      [6:0]  start_line,
	output logic      [6:0]  display_offset,
	output logic      [1:0]  display_mode,
	output logic      [6:0]  mux_lines,
	output logic             ext_supply_n,
	output logic      [5:0]  precharge_comp,
	output logic      [3:0]  phase_one_length,
	output logic      [3:0]  phase_two_length,
	output logic             display_on,
	output logic             segment_common_outputs,
	// Display memory write port
	output logic             mem_we,
	output logic      [5:0]  mem_col,
	output logic      [6:0]  mem_row,
	output logic      [7:0]  mem_data
);
	localparam int CNT_W = $clog2(ON_DELAY + 1);
	localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(ON_DELAY);
	localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

	oscd_byte_if bif ();

	logic             rstn_meta_reg;
	logic             rstn_sync_reg;
	oscd_dec_e        state_reg;
	oscd_dec_e        state_next;
	logic [7:0]       op_reg;
	logic             ext_pend_reg;
	logic [CNT_W-1:0] on_cnt_reg;
	logic [5:0]       col_ptr_reg;
	logic [6:0]       row_ptr_reg;
	logic [31:0]      ctrl_reg;

	////////////////////////////////////////////////////////////////////////
	// Serial byte receiver
	oscd_shift u_shift (
		.pclk            (pclk),
		.presetn         (presetn),
		.chip_select_n   (chip_select_n),
		.serial_clock_in (serial_clock_in),
		.serial_data_in  (serial_data_in),
		.cmd_data_sel    (cmd_data_sel),
		.bus_mode_select (bus_mode_select),
		.bif             (bif.src)
	);

	// Reset pin synchroniser; low level reloads all settings
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rstn_meta_reg <= 1'b0;
			rstn_sync_reg <= 1'b0;
		end
		else
		begin
			rstn_meta_reg <= reset_low_pin_n;
			rstn_sync_reg <= rstn_meta_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Byte classification
	wire       rst_cmd   = ~rstn_sync_reg;
	wire       byte_ok   = bif.valid & ctrl_reg[CTRL_EN_BIT];
	wire       cmd_take  = byte_ok & ~bif.dc;
	wire       dat_take  = byte_ok & bif.dc;
	wire [7:0] b         = bif.data;
	wire       op_take   = cmd_take & (state_reg == DEC_OPCODE);
	wire       p1_take   = cmd_take & (state_reg == DEC_PARAM1);
	wire       p2_take   = cmd_take & (state_reg == DEC_PARAM2);
	wire       two_par   = (b == OP_COL_WIN) | (b == OP_ROW_WIN);
	wire       one_par   = (b == OP_CONTRAST) | (b == OP_REMAP) | (b == OP_START)
		| (b == OP_OFFSET) | (b == OP_MUX) | (b == OP_MASTER)
		| (b == OP_PRECOMP) | (b == OP_PHASE);
	wire       on_cmd    = op_take & (b == OP_ON);
	wire       off_cmd   = op_take & (b == OP_OFF);
	wire       range_cmd = op_take & (b >= OP_RANGE_Q) & (b <= OP_RANGE_F);
	wire       mode_cmd  = op_take & (b >= OP_MODE_NORM) & (b <= OP_MODE_INV);
	wire       line_ok   = b[6:0] <= LINE_MAX;
	wire       mux_ok    = (b[6:0] >= MUX_MIN) & line_ok;

	// Parameter bytes of one opcode
	wire par_col1 = p1_take & (op_reg == OP_COL_WIN);
	wire par_col2 = p2_take & (op_reg == OP_COL_WIN);
	wire par_row1 = p1_take & (op_reg == OP_ROW_WIN) & line_ok;
	wire par_row2 = p2_take & (op_reg == OP_ROW_WIN) & line_ok;
	wire par_one  = p1_take & (op_reg != OP_COL_WIN) & (op_reg != OP_ROW_WIN);
	wire two_par_op = (op_reg == OP_COL_WIN) | (op_reg == OP_ROW_WIN);

	// Decoder state sequence
	always_comb
	begin
		state_next = state_reg;
		unique case (state_reg)
			DEC_OPCODE:
				if (op_take && (two_par || one_par))
					state_next = DEC_PARAM1;
			DEC_PARAM1:
				if (p1_take)
					state_next = two_par_op ? DEC_PARAM2 : DEC_OPCODE;
			DEC_PARAM2:
				if (p2_take)
					state_next = DEC_OPCODE;
			default:
				state_next = DEC_OPCODE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg <= DEC_OPCODE;
			op_reg    <= OP_NOP;
		end
		else if (rst_cmd)
			state_reg <= DEC_OPCODE;
		else
		begin
			state_reg <= state_next;
			if (op_take)
				op_reg <= b;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Address windows; the reset pin reloads them synchronously
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			col_start <= COL_START_RST;
			col_end   <= COL_END_RST;
			row_start <= ROW_START_RST;
			row_end   <= ROW_END_RST;
		end
		else if (rst_cmd)
		begin
			col_start <= COL_START_RST;
			col_end   <= COL_END_RST;
			row_start <= ROW_START_RST;
			row_end   <= ROW_END_RST;
		end
		else
		begin
			if (par_col1)
				col_start <= b[5:0];
			if (par_col2)
				col_end <= b[5:0];
			if (par_row1)
				row_start <= b[6:0];
			if (par_row2)
				row_end <= b[6:0];
		end
	end

	// Drive and geometry settings
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			contrast       <= CONTRAST_RST;
			current_range  <= RANGE_QUARTER;
			remap          <= REMAP_RST;
			start_line     <= LINE_RST;
			display_offset <= LINE_RST;
			display_mode   <= MODE_NORMAL;
			mux_lines      <= MUX_LINES_RST;
			precharge_comp <= PRECOMP_RST;
		end
		else if (rst_cmd)
		begin
			contrast       <= CONTRAST_RST;
			current_range  <= RANGE_QUARTER;
			remap          <= REMAP_RST;
			start_line     <= LINE_RST;
			display_offset <= LINE_RST;
			display_mode   <= MODE_NORMAL;
			mux_lines      <= MUX_LINES_RST;
			precharge_comp <= PRECOMP_RST;
		end
		else
		begin
			if (par_one && op_reg == OP_CONTRAST)
				contrast <= b[6:0];
			if (range_cmd)
				current_range <= b[1:0];
			if (par_one && op_reg == OP_REMAP)
				remap <= b[6:0] & REMAP_MASK;
			if (par_one && op_reg == OP_START && line_ok)
				start_line <= b[6:0];
			if (par_one && op_reg == OP_OFFSET && line_ok)
				display_offset <= b[6:0];
			if (mode_cmd)
				display_mode <= b[1:0];
			if (par_one && op_reg == OP_MUX && mux_ok)
				mux_lines <= b[6:0] + 7'h01;
			if (par_one && op_reg == OP_PRECOMP)
				precharge_comp <= b[5:0];
		end
	end

	// Phase lengths; a zero nibble is refused
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			phase_one_length <= PHASE1_RST;
			phase_two_length <= PHASE2_RST;
		end
		else if (rst_cmd)
		begin
			phase_one_length <= PHASE1_RST;
			phase_two_length <= PHASE2_RST;
		end
		else if (par_one && op_reg == OP_PHASE)
		begin
			if (b[3:0] != PHASE_INVALID)
				phase_one_length <= b[3:0];
			if (b[7:4] != PHASE_INVALID)
				phase_two_length <= b[7:4];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Master configuration held pending until display-on
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ext_pend_reg <= EXT_SUPPLY_RST;
			ext_supply_n <= EXT_SUPPLY_RST;
		end
		else if (rst_cmd)
		begin
			ext_pend_reg <= EXT_SUPPLY_RST;
			ext_supply_n <= EXT_SUPPLY_RST;
		end
		else
		begin
			if (par_one && op_reg == OP_MASTER)
				ext_pend_reg <= b[MASTER_BIT];
			if (on_cmd)
				ext_supply_n <= ext_pend_reg;
		end
	end

	// Display on/off and delayed output enable
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			display_on             <= 1'b0;
			segment_common_outputs <= 1'b0;
			on_cnt_reg             <= '0;
		end
		else if (rst_cmd || off_cmd)
		begin
			display_on             <= 1'b0;
			segment_common_outputs <= 1'b0;
			on_cnt_reg             <= '0;
		end
		else if (on_cmd && !display_on)
		begin
			display_on <= 1'b1;
			on_cnt_reg <= CNT_LOAD;
		end
		else if (on_cnt_reg != '0)
		begin
			on_cnt_reg <= on_cnt_reg - CNT_ONE;
			if (on_cnt_reg == CNT_ONE)
				segment_common_outputs <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Memory pointer advance within the window
	wire       vert     = remap[REMAP_VERT];
	wire       col_last = col_ptr_reg == col_end;
	wire       row_last = row_ptr_reg == row_end;
	wire [5:0] col_inc  = col_last ? col_start : col_ptr_reg + 6'h01;
	wire [6:0] row_inc  = row_last ? row_start : row_ptr_reg + 7'h01;
	wire [5:0] col_nx   = (!vert || row_last) ? col_inc : col_ptr_reg;
	wire [6:0] row_nx   = (vert || col_last) ? row_inc : row_ptr_reg;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			col_ptr_reg <= COL_START_RST;
			row_ptr_reg <= ROW_START_RST;
		end
		else if (rst_cmd)
		begin
			col_ptr_reg <= COL_START_RST;
			row_ptr_reg <= ROW_START_RST;
		end
		else if (par_col1)
			col_ptr_reg <= b[5:0];
		else if (par_row1)
			row_ptr_reg <= b[6:0];
		else if (dat_take)
		begin
			col_ptr_reg <= col_nx;
			row_ptr_reg <= row_nx;
		end
	end

	// Display memory write strobe
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mem_we   <= 1'b0;
			mem_col  <= COL_START_RST;
			mem_row  <= ROW_START_RST;
			mem_data <= 8'h00;
		end
		else
		begin
			mem_we <= dat_take;
			if (dat_take)
			begin
				mem_col  <= col_ptr_reg;
				mem_row  <= row_ptr_reg;
				mem_data <= b;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// APB decode; serial side has no read path, APB gives read-back
	wire        setup  = psel & ~penable;
	wire        hit_st = paddr == ADDR_STATUS;
	wire        hit_wn = paddr == ADDR_WINDOW;
	wire        hit_cf = paddr == ADDR_CONFIG;
	wire        hit_ln = paddr == ADDR_LINES;
	wire        hit_ct = paddr == ADDR_CTRL;
	wire        mapped = hit_st | hit_wn | hit_cf | hit_ln | hit_ct;
	wire        wr_acc = psel & penable & pready & pwrite & ~pslverr;
	wire [31:0] st_w   = {22'h0, state_reg, ext_pend_reg, ext_supply_n,
		display_mode, current_range, segment_common_outputs, display_on};
	wire [31:0] wn_w   = {6'h00, row_end, row_start, col_end, col_start};
	wire [31:0] cf_w   = {4'h0, contrast, remap, phase_two_length,
		phase_one_length, precharge_comp};
	wire [31:0] ln_w   = {11'h000, mux_lines, display_offset, start_line};
	wire [31:0] rd_w   = hit_st ? st_w : hit_wn ? wn_w : hit_cf ? cf_w
		: hit_ln ? ln_w : hit_ct ? ctrl_reg : 32'h0000_0000;

	// APB answer in the first access cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end
		else
		begin
			pready  <= setup;
			pslverr <= setup & ~mapped;
			if (setup && !pwrite)
				prdata <= rd_w;
		end
	end

	// Control register: bit 0 enables byte acceptance
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ctrl_reg <= CTRL_RST;
		else if (wr_acc && hit_ct)
			ctrl_reg <= pwdata & CTRL_RST;
	end

	////////////////////////////////////////////////////////////////////////
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_disp_on: assert property (
		(on_cmd && !display_on && !rst_cmd) |=> display_on && !segment_common_outputs)
		else $error("display-on not taken");
	a_disp_off: assert property (
		(off_cmd && !rst_cmd) |=> !display_on && !segment_common_outputs)
		else $error("display-off not taken");
	a_out_wait: assert property (
		$rose(segment_common_outputs) |-> display_on && $past(on_cnt_reg) == CNT_ONE)
		else $error("outputs enabled early");
	a_range_full: assert property (
		(range_cmd && b == OP_RANGE_F && !rst_cmd) |=> current_range == RANGE_FULL)
		else $error("full range not selected");
	a_master_hold: assert property (
		(par_one && op_reg == OP_MASTER && !rst_cmd) |=> $stable(ext_supply_n))
		else $error("master config applied early");
	a_phase_zero: assert property (
		(par_one && op_reg == OP_PHASE && b[3:0] == PHASE_INVALID && !rst_cmd)
		|=> $stable(phase_one_length))
		else $error("zero phase accepted");
	a_mux_set: assert property (
		(par_one && op_reg == OP_MUX && mux_ok && !rst_cmd)
		|=> mux_lines == $past(b[6:0]) + 7'h01)
		else $error("multiplex ratio wrong");
	a_nop_still: assert property (
		(op_take && b == OP_NOP && !rst_cmd)
		|=> $stable(display_mode) && $stable(display_on) && state_reg == DEC_OPCODE)
		else $error("nop changed state");
	a_data_write: assert property (
		dat_take |=> mem_we && mem_data == $past(b) && mem_col == $past(col_ptr_reg))
		else $error("data byte not written");
	a_col_param: assert property (
		(par_col2 && !rst_cmd) ##1 1 |-> col_end == $past(b[5:0]))
		else $error("column end not loaded");
endmodule : oscd_top
`default_nettype wire

/* File: bench/oscd_host_model.sv */
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Host side of the write-only serial link
module oscd_host_model
(
	// Clock
	input  wire logic pclk,
	// Serial pins
	output var  logic cs_n,
	output var  logic sclk,
	output var  logic sdata,
	output var  logic dc
);
	timeunit 1ns;
	timeprecision 1ps;

	// Idle: deselected, clock standing low
	initial
	begin
		cs_n = 1'b1;
		sclk = 1'b0;
		sdata = 1'b0;
		dc = 1'b0;
	end

	// One byte per select; no read is ever attempted
	task automatic send(input logic d_c, input logic [7:0] b);
		cs_n <= 1'b0;
		dc <= d_c;
		for (int i = 7; i >= 0; i--)
		begin
			sdata <= b[i];
			repeat (8) @(posedge pclk);
			sclk <= 1'b1;
			repeat (8) @(posedge pclk);
			sclk <= 1'b0;
		end
		repeat (4) @(posedge pclk);
		cs_n <= 1'b1;
		sdata <= ~b[0]; // Released line does not keep its value
		@(posedge pclk);
	endtask : send
endmodule : oscd_host_model
`default_nettype wire

/* File: bench/testbench.sv */
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module testbench
	import oscd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rpn, bms;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        cs_n, sclk, sdata, dc, er;
	logic [5:0]  col_start, col_end, precharge_comp, mem_col;
	logic [6:0]  row_start, row_end, contrast, remap, start_line, display_offset, mux_lines;
	logic [6:0]  mem_row;
	logic [1:0]  current_range, display_mode;
	logic [3:0]  phase_one_length, phase_two_length;
	logic        ext_supply_n, display_on, segment_common_outputs, mem_we;
	logic [7:0]  mem_data;
	logic [20:0] cap;
	int          nw, fails, checks_done;

	oscd_top #(.ON_DELAY(20)) u_dut (
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .chip_select_n(cs_n), .reset_low_pin_n(rpn),
		.bus_mode_select(bms), .cmd_data_sel(dc), .serial_clock_in(sclk),
		.serial_data_in(sdata), .col_start(col_start), .col_end(col_end),
		.row_start(row_start), .row_end(row_end), .contrast(contrast),
		.current_range(current_range), .remap(remap), .start_line(start_line),
		.display_offset(display_offset), .display_mode(display_mode),
		.mux_lines(mux_lines), .ext_supply_n(ext_supply_n),
		.precharge_comp(precharge_comp), .phase_one_length(phase_one_length),
		.phase_two_length(phase_two_length), .display_on(display_on),
		.segment_common_outputs(segment_common_outputs), .mem_we(mem_we),
		.mem_col(mem_col), .mem_row(mem_row), .mem_data(mem_data)
	);
	oscd_host_model u_host (.pclk(pclk), .cs_n(cs_n), .sclk(sclk), .sdata(sdata), .dc(dc));

	// Clock
	initial
	begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// Memory write capture
	always @(posedge pclk)
		if (mem_we === 1'b1)
		begin
			cap = {mem_col, mem_row, mem_data};
			nw++;
		end

	// Comparison
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			fails++;
			$display("FAIL %0t got %0h expected %0h", $time, got, exp);
		end
	endtask : chk

	// APB transfer, held until pready
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// pready ends this wait; the watchdog covers a pready that never comes
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	// Serial byte then settle
	task automatic sb(input logic d, input logic [7:0] b);
		u_host.send(d, b);
		repeat (10) @(posedge pclk);
	endtask : sb

	task automatic t_reset;
		chk({col_start, col_end, row_start, row_end}, {6'h00, 6'h3F, 7'h00, 7'h4F});
		chk({contrast, current_range, remap}, {7'h40, 2'h0, 7'h00});
		chk({precharge_comp, phase_one_length, phase_two_length}, {6'h08, 4'h3, 4'h5});
		chk({display_on, ext_supply_n}, 2'b01);
	endtask : t_reset

	task automatic t_apb;
		apb(1'b0, ADDR_CTRL, 32'h0);
		chk(rd, 32'h0000_0001);
		apb(1'b0, 12'h020, 32'h0);
		chk(32'(er), 32'h1);
	endtask : t_apb

	task automatic t_settings;
		sb(0, OP_COL_WIN);
		sb(0, 8'h03);
		sb(0, 8'h2A);
		chk({col_start, col_end}, {6'h03, 6'h2A});
		sb(0, OP_ROW_WIN);
		sb(0, 8'h05);
		sb(0, 8'h40);
		chk({row_start, row_end}, {7'h05, 7'h40});
		sb(0, OP_CONTRAST);
		sb(0, 8'h7F);
		chk(32'(contrast), 32'h7F);
		for (int i = 0; i < 3; i++)
		begin
			sb(0, OP_RANGE_Q + 8'(i));
			chk(32'(current_range), 32'(i));
		end
		// Leaves vertical increment on for the data scenario
		sb(0, OP_REMAP);
		sb(0, 8'h7F);
		chk(32'(remap), 32'h57);
		sb(0, OP_START);
		sb(0, 8'h50);
		sb(0, OP_START);
		sb(0, 8'h4F);
		chk(32'(start_line), 32'h4F);
		sb(0, OP_OFFSET);
		sb(0, 8'h10);
		chk(32'(display_offset), 32'h10);
		for (int i = 3; i >= 0; i--)
		begin
			sb(0, OP_MODE_NORM + 8'(i));
			chk(32'(display_mode), 32'(i));
		end
		sb(0, OP_MUX);
		sb(0, 8'h0E);
		sb(0, OP_MUX);
		sb(0, 8'h0F);
		chk(32'(mux_lines), 32'h10);
		sb(0, OP_PRECOMP);
		sb(0, 8'h28);
		chk(32'(precharge_comp), 32'h28);
		sb(0, OP_PHASE);
		sb(0, 8'h02);
		chk({phase_one_length, phase_two_length}, 8'h25);
		sb(0, OP_NOP);
		chk({contrast, phase_one_length}, {7'h7F, 4'h2});
	endtask : t_settings

	task automatic t_power;
		sb(0, OP_MASTER);
		sb(0, 8'h00);
		chk(32'(ext_supply_n), 32'h1);
		// Check well inside the 20-cycle output delay, then well after it
		u_host.send(1'b0, OP_ON);
		chk({display_on, ext_supply_n, segment_common_outputs}, 3'b100);
		repeat (20) @(posedge pclk);
		chk(32'(segment_common_outputs), 32'h1);
		sb(0, OP_OFF);
		chk({display_on, segment_common_outputs}, 2'b00);
	endtask : t_power

	task automatic t_data;
		sb(1, 8'hA5);
		chk(32'(cap), 32'({6'h03, 7'h05, 8'hA5}));
		sb(1, OP_CONTRAST);
		chk(32'(cap), 32'({6'h03, 7'h06, 8'h81}));
		chk(32'(nw), 32'h2);
	endtask : t_data

	task automatic t_block;
		bms <= 1'b1;
		sb(0, OP_CONTRAST);
		sb(0, 8'h11);
		bms <= 1'b0;
		apb(1'b1, ADDR_CTRL, 32'h0);
		sb(0, OP_CONTRAST);
		sb(0, 8'h22);
		apb(1'b1, ADDR_CTRL, 32'h1);
		chk(32'(contrast), 32'h7F);
		// Reset pin held low for 3 us
		rpn <= 1'b0;
		repeat (300) @(posedge pclk);
		rpn <= 1'b1;
		repeat (8) @(posedge pclk);
		chk({contrast, col_end}, {7'h40, 6'h3F});
	endtask : t_block

	// Verdict
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_of_test

	// Watchdog
	initial
	begin
		repeat (60000) @(posedge pclk);
		fails++;
		$display("FAIL %0t timeout", $time);
		end_of_test();
	end

	// Main sequence
	initial
	begin
		{presetn, rpn, bms, psel, penable, pwrite} = 6'b000000;
		paddr = 12'h000;
		pwdata = 32'h0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		// Reset pin held low for 3 us
		repeat (300) @(posedge pclk);
		rpn <= 1'b1;
		repeat (6) @(posedge pclk);
		t_reset();
		t_apb();
		t_settings();
		t_power();
		t_data();
		t_block();
		end_of_test();
	end
endmodule : testbench
`default_nettype wire
